// File: core/cdmr_pkg.sv
// Constants of the codec digital mix router: register map, fields, gains.
// Assumes registers are reached by their offsets on a plain 8-bit address port.
package cdmr_pkg;

   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned REG_W     = 16;
   localparam int unsigned SAMPLE_W  = 24;

   localparam logic [ADDR_W-1:0] IFACE_ROUTE_OFS  = 8'h18;
   localparam logic [ADDR_W-1:0] DAC_SIDETONE_OFS = 8'h20;
   localparam logic [ADDR_W-1:0] ADC_POLARITY_OFS = 8'h26;

   // Interface routing register fields
   localparam int unsigned IR_LDAC_FLIP_BIT = 12;
   localparam int unsigned IR_RDAC_FLIP_BIT = 11;
   localparam int unsigned IR_BOOST_LSB     = 9;
   localparam int unsigned IR_LOUT_SEL_BIT  = 7;
   localparam int unsigned IR_ROUT_SEL_BIT  = 6;
   localparam int unsigned IR_LDAC_SEL_BIT  = 5;
   localparam int unsigned IR_RDAC_SEL_BIT  = 4;
   localparam int unsigned BOOST_W          = 2;

   // Sidetone control register fields
   localparam int unsigned DS_LGAIN_LSB = 8;
   localparam int unsigned DS_RGAIN_LSB = 4;
   localparam int unsigned DS_LSRC_LSB  = 2;
   localparam int unsigned DS_RSRC_LSB  = 0;
   localparam int unsigned GAIN_W       = 4;
   localparam int unsigned SRC_W        = 2;

   // ADC polarity register fields
   localparam int unsigned AP_LFLIP_BIT = 1;
   localparam int unsigned AP_RFLIP_BIT = 0;

   localparam logic [REG_W-1:0] IFACE_ROUTE_RST  = 16'h0050;
   localparam logic [REG_W-1:0] DAC_SIDETONE_RST = 16'h0000;
   localparam logic [REG_W-1:0] ADC_POLARITY_RST = 16'h0000;
   localparam logic [REG_W-1:0] IFACE_ROUTE_MASK  = 16'h1ef0;
   localparam logic [REG_W-1:0] DAC_SIDETONE_MASK = 16'h0fff;
   localparam logic [REG_W-1:0] ADC_POLARITY_MASK = 16'h0003;

   typedef enum logic [SRC_W-1:0] {
      CDMR_ST_NONE  = 2'h0,
      CDMR_ST_LEFT  = 2'h1,
      CDMR_ST_RIGHT = 2'h2,
      CDMR_ST_RSVD  = 2'h3
   } cdmr_st_src_type;

   localparam int unsigned      GAIN_FRAC  = 15;
   localparam int unsigned      GAIN_QW    = 17;
   localparam logic [GAIN_W-1:0] GAIN_UNITY = 4'hc;

   // Linear gain in Q1.15 for each 3 dB step of the sidetone volume code
   function automatic logic [GAIN_QW-1:0] cdmr_gain_q15(input logic [GAIN_W-1:0] code);
      case (code)
         4'h0:    cdmr_gain_q15 = 17'h00207;
         4'h1:    cdmr_gain_q15 = 17'h002de;
         4'h2:    cdmr_gain_q15 = 17'h0040c;
         4'h3:    cdmr_gain_q15 = 17'h005b8;
         4'h4:    cdmr_gain_q15 = 17'h00813;
         4'h5:    cdmr_gain_q15 = 17'h00b68;
         4'h6:    cdmr_gain_q15 = 17'h0101d;
         4'h7:    cdmr_gain_q15 = 17'h016c3;
         4'h8:    cdmr_gain_q15 = 17'h02027;
         4'h9:    cdmr_gain_q15 = 17'h02d6b;
         4'ha:    cdmr_gain_q15 = 17'h04027;
         4'hb:    cdmr_gain_q15 = 17'h05a9e;
         default: cdmr_gain_q15 = 17'h08000;
      endcase
   endfunction

endpackage

// File: core/cdmr_lane_if.sv
// Carrier between the router core and one DAC lane.
// Assumes the core drives selects and samples, the lane returns its result.
`timescale 1ns/10ps
interface cdmr_lane_if #(parameter int unsigned W = 24);
   logic signed [W-1:0] iface_l;
   logic signed [W-1:0] iface_r;
   logic                in_valid;
   logic                in_sel;
   logic                flip;
   logic [1:0]          boost;
   logic signed [W-1:0] sidetone;
   logic signed [W-1:0] out_data;
   logic                out_valid;

   modport lane (input iface_l, iface_r, in_valid, in_sel, flip, boost, sidetone,
                 output out_data, out_valid);
   modport core (output iface_l, iface_r, in_valid, in_sel, flip, boost, sidetone,
                 input out_data, out_valid);
endinterface // cdmr_lane_if

// File: core/cdmr_sidetone_scale.sv
// Sidetone source pick and volume scaling for one DAC channel.
// Assumes the ADC samples given are held post-filter words.
`timescale 1ns/10ps
module cdmr_sidetone_scale
   import cdmr_pkg::*;
#(
   parameter int unsigned W = cdmr_pkg::SAMPLE_W
) (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic signed [W-1:0]           adc_l,
   input  wire logic signed [W-1:0]           adc_r,
   input  wire logic [cdmr_pkg::SRC_W-1:0]    source,
   input  wire logic [cdmr_pkg::GAIN_W-1:0]   gain,
   input  wire logic                          enable,
   output logic signed [W-1:0]                scaled
);
   logic signed [W-1:0]  pick;
   logic signed [W+17:0] prod;

   always_comb begin
      unique case (cdmr_st_src_type'(source))
         CDMR_ST_LEFT:  pick = adc_l;
         CDMR_ST_RIGHT: pick = adc_r;
         default:       pick = '0;
      endcase
      if (!enable) begin
         pick = '0;
      end
      prod = (W+18)'(pick) * (W+18)'($signed({1'b0, cdmr_gain_q15(gain)}));
   end

   // Unity gain is exactly 2^15, so the top code never overflows the word
   always_ff @(posedge clk) begin
      if (rst) begin
         scaled <= '0;
      end else begin
         scaled <= prod[GAIN_FRAC +: W];
      end
   end
endmodule // cdmr_sidetone_scale

// File: core/cdmr_dac_lane.sv
// One DAC data path: source select, polarity, boost, sidetone add, clamp.
// Assumes one word per in_valid; the result appears one cycle later.
`timescale 1ns/10ps
module cdmr_dac_lane
   import cdmr_pkg::*;
#(
   parameter int unsigned W = cdmr_pkg::SAMPLE_W
) (
   input  wire logic clk,
   input  wire logic rst,
   cdmr_lane_if.lane lane
);
   localparam int unsigned EW = W + 5;
   localparam logic signed [EW-1:0] MAX_E = {{(EW-W+1){1'b0}}, {(W-1){1'b1}}};
   localparam logic signed [EW-1:0] MIN_E = ~MAX_E;

   logic signed [EW-1:0] picked;
   logic signed [EW-1:0] flipped;
   logic signed [EW-1:0] boosted;
   logic signed [EW-1:0] summed;
   logic signed [W-1:0]  clamped;

   // Wide arithmetic so only the final sum needs clamping
   always_comb begin
      picked  = EW'(lane.in_sel ? lane.iface_r : lane.iface_l);
      flipped = lane.flip ? -picked : picked;
      boosted = flipped <<< lane.boost;
      summed  = boosted + EW'(lane.sidetone);
      if (summed > MAX_E) begin
         clamped = MAX_E[W-1:0];
      end else if (summed < MIN_E) begin
         clamped = MIN_E[W-1:0];
      end else begin
         clamped = summed[W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lane.out_data  <= '0;
         lane.out_valid <= 1'b0;
      end else begin
         lane.out_valid <= lane.in_valid;
         if (lane.in_valid) begin
            lane.out_data <= clamped;
         end
      end
   end
endmodule // cdmr_dac_lane

// File: core/cdmr_mix_router.sv
// Digital mixing core: ADC to interface routing, interface to DAC routing
// with boost and sidetone. Assumes sample strobes and a plain register port
// synchronous to clk.
`timescale 1ns/10ps

// Operation
// - Bit 7 picks left interface output source: left ADC or right ADC.
// - Bit 6 picks right interface output source; resets to right ADC.
// - ADC polarity bit 1 negates left ADC samples before routing.
// - ADC polarity bit 0 negates right ADC samples before routing.
// - Routing bit 12 inverts the left DAC data path.
// - Routing bit 11 inverts the right DAC data path.
// - Bit 5 picks left DAC input: left or right interface channel.
// - Bit 4 picks right DAC input; resets to right interface channel.
// - Bits 10:9 boost interface DAC data by 0, 6, 12 or 18 dB.
// - Sidetone only when ADC and DAC share one sample rate.
// - Scaled sidetone is added to each DAC channel's interface data.
// - Sidetone is taken after the ADC high-pass filter.
// - Bits 3:2 pick left DAC sidetone source: none, left, right.
// - Bits 1:0 pick right DAC sidetone source with the same coding.
// - Sidetone volumes: left at bits 11:8, right at bits 7:4.
// - Volume steps 3 dB from -36 dB; codes 12 to 15 give 0 dB.
module cdmr_mix_router
   import cdmr_pkg::*;
#(
   parameter int unsigned W = cdmr_pkg::SAMPLE_W
) (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic [cdmr_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [cdmr_pkg::REG_W-1:0]    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic [cdmr_pkg::REG_W-1:0]         reg_rdata,
   input  wire logic signed [W-1:0]           adc_l_hpf,
   input  wire logic signed [W-1:0]           adc_r_hpf,
   input  wire logic                          adc_valid,
   input  wire logic                          rates_match,
   input  wire logic signed [W-1:0]           iface_l_in,
   input  wire logic signed [W-1:0]           iface_r_in,
   input  wire logic                          iface_in_valid,
   output logic signed [W-1:0]                iface_l_out,
   output logic signed [W-1:0]                iface_r_out,
   output logic                               iface_out_valid,
   output logic signed [W-1:0]                dac_l_data,
   output logic signed [W-1:0]                dac_r_data,
   output logic                               dac_valid
);
   import cdmr_pkg::*;

   localparam logic signed [W-1:0] MAX_S = {1'b0, {(W-1){1'b1}}};
   localparam logic signed [W-1:0] MIN_S = ~MAX_S;

   logic [REG_W-1:0]     iface_route_q;
   logic [REG_W-1:0]     dac_sidetone_q;
   logic [REG_W-1:0]     adc_polarity_q;
   logic signed [W-1:0]  adc_l_q;
   logic signed [W-1:0]  adc_r_q;
   logic signed [W-1:0]  adc_l_pol;
   logic signed [W-1:0]  adc_r_pol;

   logic                 iface_left_out_select;
   logic                 iface_right_out_select;
   logic                 left_adc_polarity_flip;
   logic                 right_adc_polarity_flip;
   logic [BOOST_W-1:0]   dac_boost;
   logic [1:0]           dac_in_sel;
   logic [1:0]           dac_flip;
   logic [SRC_W-1:0]     st_src [2];
   logic [GAIN_W-1:0]    st_gain [2];
   logic signed [W-1:0]  st_scaled [2];
   logic signed [W-1:0]  lane_out [2];
   logic [1:0]           lane_valid;

   // Field decode
   assign iface_left_out_select   = iface_route_q[IR_LOUT_SEL_BIT];
   assign iface_right_out_select  = iface_route_q[IR_ROUT_SEL_BIT];
   assign left_adc_polarity_flip  = adc_polarity_q[AP_LFLIP_BIT];
   assign right_adc_polarity_flip = adc_polarity_q[AP_RFLIP_BIT];
   assign dac_boost     = iface_route_q[IR_BOOST_LSB +: BOOST_W];
   assign dac_in_sel[0] = iface_route_q[IR_LDAC_SEL_BIT];
   assign dac_in_sel[1] = iface_route_q[IR_RDAC_SEL_BIT];
   assign dac_flip[0]   = iface_route_q[IR_LDAC_FLIP_BIT];
   assign dac_flip[1]   = iface_route_q[IR_RDAC_FLIP_BIT];
   assign st_src[0]     = dac_sidetone_q[DS_LSRC_LSB +: SRC_W];
   assign st_src[1]     = dac_sidetone_q[DS_RSRC_LSB +: SRC_W];
   assign st_gain[0]    = dac_sidetone_q[DS_LGAIN_LSB +: GAIN_W];
   assign st_gain[1]    = dac_sidetone_q[DS_RGAIN_LSB +: GAIN_W];

   // Register writes; unused bits are never stored so they read as zero
   always_ff @(posedge clk) begin
      if (rst) begin
         iface_route_q <= IFACE_ROUTE_RST;
      end else if (reg_wr && reg_addr == IFACE_ROUTE_OFS) begin
         iface_route_q <= reg_wdata & IFACE_ROUTE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dac_sidetone_q <= DAC_SIDETONE_RST;
      end else if (reg_wr && reg_addr == DAC_SIDETONE_OFS) begin
         dac_sidetone_q <= reg_wdata & DAC_SIDETONE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         adc_polarity_q <= ADC_POLARITY_RST;
      end else if (reg_wr && reg_addr == ADC_POLARITY_OFS) begin
         adc_polarity_q <= reg_wdata & ADC_POLARITY_MASK;
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            IFACE_ROUTE_OFS:  reg_rdata <= iface_route_q;
            DAC_SIDETONE_OFS: reg_rdata <= dac_sidetone_q;
            ADC_POLARITY_OFS: reg_rdata <= adc_polarity_q;
            default:          reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Negating full-scale negative would wrap, so it clamps to positive full scale
   function automatic logic signed [W-1:0] neg_sat(input logic signed [W-1:0] x);
      neg_sat = (x == MIN_S) ? MAX_S : -x;
   endfunction

   assign adc_l_pol = left_adc_polarity_flip  ? neg_sat(adc_l_hpf) : adc_l_hpf;
   assign adc_r_pol = right_adc_polarity_flip ? neg_sat(adc_r_hpf) : adc_r_hpf;

   always_ff @(posedge clk) begin
      if (rst) begin
         iface_l_out     <= '0;
         iface_r_out     <= '0;
         iface_out_valid <= 1'b0;
      end else begin
         iface_out_valid <= adc_valid;
         if (adc_valid) begin
            iface_l_out <= iface_left_out_select  ? adc_r_pol : adc_l_pol;
            iface_r_out <= iface_right_out_select ? adc_r_pol : adc_l_pol;
         end
      end
   end

   // Sidetone uses the unflipped high-pass output, held between ADC strobes
   always_ff @(posedge clk) begin
      if (rst) begin
         adc_l_q <= '0;
         adc_r_q <= '0;
      end else if (adc_valid) begin
         adc_l_q <= adc_l_hpf;
         adc_r_q <= adc_r_hpf;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_lane
      cdmr_lane_if #(.W(W)) lane_bus ();

      // Mismatched rates would smear the sidetone, so it is held off
      cdmr_sidetone_scale #(.W(W)) u_scale (
         .clk    (clk),
         .rst    (rst),
         .adc_l  (adc_l_q),
         .adc_r  (adc_r_q),
         .source (st_src[i]),
         .gain   (st_gain[i]),
         .enable (rates_match),
         .scaled (st_scaled[i])
      );

      assign lane_bus.iface_l  = iface_l_in;
      assign lane_bus.iface_r  = iface_r_in;
      assign lane_bus.in_valid = iface_in_valid;
      assign lane_bus.in_sel   = dac_in_sel[i];
      assign lane_bus.flip     = dac_flip[i];
      assign lane_bus.boost    = dac_boost;
      assign lane_bus.sidetone = st_scaled[i];
      assign lane_out[i]       = lane_bus.out_data;
      assign lane_valid[i]     = lane_bus.out_valid;

      cdmr_dac_lane #(.W(W)) u_lane (
         .clk  (clk),
         .rst  (rst),
         .lane (lane_bus.lane)
      );
   end

   assign dac_l_data = lane_out[0];
   assign dac_r_data = lane_out[1];
   assign dac_valid  = &lane_valid;

   property p_left_out_route;
      @(posedge clk) disable iff (rst)
      adc_valid && iface_left_out_select && !right_adc_polarity_flip
      |=> iface_out_valid && iface_l_out == $past(adc_r_hpf);
   endproperty
   a_left_out_route: assert property (p_left_out_route)
      else $error("left interface output not from selected ADC");

   property p_right_out_route;
      @(posedge clk) disable iff (rst)
      adc_valid && !iface_right_out_select && !left_adc_polarity_flip
      |=> iface_r_out == $past(adc_l_hpf);
   endproperty
   a_right_out_route: assert property (p_right_out_route)
      else $error("right interface output not from selected ADC");

   property p_left_adc_flip;
      @(posedge clk) disable iff (rst)
      adc_valid && !iface_left_out_select && left_adc_polarity_flip && adc_l_hpf != MIN_S
      |=> iface_l_out == -$past(adc_l_hpf);
   endproperty
   a_left_adc_flip: assert property (p_left_adc_flip)
      else $error("left ADC sample not negated");

   property p_right_adc_flip;
      @(posedge clk) disable iff (rst)
      adc_valid && iface_right_out_select && right_adc_polarity_flip && adc_r_hpf != MIN_S
      |=> iface_r_out == -$past(adc_r_hpf);
   endproperty
   a_right_adc_flip: assert property (p_right_adc_flip)
      else $error("right ADC sample not negated");

   property p_left_dac_flip;
      @(posedge clk) disable iff (rst)
      iface_in_valid && dac_flip[0] && !dac_in_sel[0] && dac_boost == '0
         && st_scaled[0] == '0 && iface_l_in != MIN_S
      |=> dac_valid && dac_l_data == -$past(iface_l_in);
   endproperty
   a_left_dac_flip: assert property (p_left_dac_flip)
      else $error("left DAC path not inverted");

   property p_right_dac_flip;
      @(posedge clk) disable iff (rst)
      iface_in_valid && dac_flip[1] && dac_in_sel[1] && dac_boost == '0
         && st_scaled[1] == '0 && iface_r_in != MIN_S
      |=> dac_r_data == -$past(iface_r_in);
   endproperty
   a_right_dac_flip: assert property (p_right_dac_flip)
      else $error("right DAC path not inverted");

   property p_left_dac_select;
      @(posedge clk) disable iff (rst)
      iface_in_valid && dac_in_sel[0] && !dac_flip[0] && dac_boost == '0
         && st_scaled[0] == '0
      |=> dac_l_data == $past(iface_r_in);
   endproperty
   a_left_dac_select: assert property (p_left_dac_select)
      else $error("left DAC input not from selected channel");

   property p_right_dac_select;
      @(posedge clk) disable iff (rst)
      iface_in_valid && !dac_in_sel[1] && !dac_flip[1] && dac_boost == '0
         && st_scaled[1] == '0
      |=> dac_r_data == $past(iface_l_in);
   endproperty
   a_right_dac_select: assert property (p_right_dac_select)
      else $error("right DAC input not from selected channel");

   property p_boost_six;
      @(posedge clk) disable iff (rst)
      iface_in_valid && !dac_in_sel[0] && !dac_flip[0] && dac_boost == 2'h1
         && st_scaled[0] == '0 && iface_l_in[W-1:W-3] == 3'h0
      |=> dac_l_data == ($past(iface_l_in) <<< 1);
   endproperty
   a_boost_six: assert property (p_boost_six)
      else $error("6 dB boost not a doubling");

   property p_sidetone_add;
      @(posedge clk) disable iff (rst)
      iface_in_valid && !dac_in_sel[0] && !dac_flip[0] && dac_boost == '0
         && iface_l_in == '0
      |=> dac_l_data == $past(st_scaled[0]);
   endproperty
   a_sidetone_add: assert property (p_sidetone_add)
      else $error("sidetone not added to left DAC data");

   property p_rate_gate;
      @(posedge clk) disable iff (rst)
      !rates_match |=> st_scaled[0] == '0 && st_scaled[1] == '0;
   endproperty
   a_rate_gate: assert property (p_rate_gate)
      else $error("sidetone active under mismatched rates");

   property p_sidetone_tap;
      @(posedge clk) disable iff (rst)
      adc_valid ##1 (rates_match && st_src[0] == CDMR_ST_LEFT && st_gain[0] >= GAIN_UNITY)
      |=> st_scaled[0] == $past(adc_l_hpf, 2);
   endproperty
   a_sidetone_tap: assert property (p_sidetone_tap)
      else $error("sidetone not tapped from filtered ADC sample");

   property p_left_src_none;
      @(posedge clk) disable iff (rst)
      st_src[0] == CDMR_ST_NONE || st_src[0] == CDMR_ST_RSVD |=> st_scaled[0] == '0;
   endproperty
   a_left_src_none: assert property (p_left_src_none)
      else $error("left sidetone present with no source");

   property p_right_src_right;
      @(posedge clk) disable iff (rst)
      rates_match && st_src[1] == CDMR_ST_RIGHT && st_gain[1] == 4'hf
      |=> st_scaled[1] == $past(adc_r_q);
   endproperty
   a_right_src_right: assert property (p_right_src_right)
      else $error("right sidetone not from right ADC at unity");

   property p_gain_floor;
      @(posedge clk) disable iff (rst)
      rates_match && st_src[1] == CDMR_ST_LEFT && st_gain[1] == '0 && adc_l_q == MAX_S
      |=> st_scaled[1] == W'((W+18)'(MAX_S) * 519 >>> GAIN_FRAC);
   endproperty
   a_gain_floor: assert property (p_gain_floor)
      else $error("lowest sidetone volume not -36 dB");

   property p_saturate;
      @(posedge clk) disable iff (rst)
      iface_in_valid && !dac_in_sel[0] && !dac_flip[0] && dac_boost == 2'h3
         && iface_l_in == MAX_S && st_scaled[0] >= 0
      |=> dac_l_data == MAX_S;
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("boosted DAC sum wrapped instead of clamping");

   property p_read_answer;
      @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == IFACE_ROUTE_OFS |=> reg_rdata == $past(iface_route_q)
         ##1 ($past(reg_rd) || reg_rdata == '0);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("register read answer wrong or held too long");

endmodule // cdmr_mix_router

// File: sim/cdmr_far_model.sv
// Far-side model: ADC filter outputs and interface receiver words.
// Assumes the bench calls its tasks; lines are scrambled between strobes.
`timescale 1ns/10ps
module cdmr_far_model
   import cdmr_pkg::*;
(
   input  wire logic                     clk,
   output logic signed [SAMPLE_W-1:0]    adc_l,
   output logic signed [SAMPLE_W-1:0]    adc_r,
   output logic                          adc_vld,
   output logic signed [SAMPLE_W-1:0]    if_l,
   output logic signed [SAMPLE_W-1:0]    if_r,
   output logic                          if_vld
);
   initial begin
      {adc_l, adc_r, adc_vld, if_l, if_r, if_vld} = '0;
   end
   // Words are only valid beside the strobe; inverted after so stale data cannot match
   task automatic adc(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
      @(posedge clk);
      {adc_l, adc_r, adc_vld} <= {l, r, 1'b1};
      @(posedge clk);
      {adc_l, adc_r, adc_vld} <= {~l, ~r, 1'b0};
   endtask
   task automatic ifw(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
      @(posedge clk);
      {if_l, if_r, if_vld} <= {l, r, 1'b1};
      @(posedge clk);
      {if_l, if_r, if_vld} <= {~l, ~r, 1'b0};
   endtask
endmodule // cdmr_far_model

// File: sim/testbench.sv
// Bench of the digital mix router: register port, ADC and DAC routes.
// Assumes the far-side model supplies sample strobes on the same clock.
`timescale 1ns/10ps
module testbench;
   import cdmr_pkg::*;
   logic                        clk, rst, wr, rd, rates_match;
   logic [ADDR_W-1:0]           addr;
   logic [REG_W-1:0]            wdata, rdata;
   logic signed [SAMPLE_W-1:0]  adc_l, adc_r, if_l, if_r, out_l, out_r, dac_l, dac_r, el, er;
   logic                        adc_vld, if_vld, out_vld, dac_vld;
   int                          n_fail = 0;
   int                          compares = 0;

   cdmr_mix_router dut_u (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .adc_l_hpf(adc_l), .adc_r_hpf(adc_r),
      .adc_valid(adc_vld), .rates_match(rates_match), .iface_l_in(if_l), .iface_r_in(if_r),
      .iface_in_valid(if_vld), .iface_l_out(out_l), .iface_r_out(out_r),
      .iface_out_valid(out_vld), .dac_l_data(dac_l), .dac_r_data(dac_r), .dac_valid(dac_vld));
   cdmr_far_model far_u (.clk(clk), .adc_l(adc_l), .adc_r(adc_r), .adc_vld(adc_vld),
      .if_l(if_l), .if_r(if_r), .if_vld(if_vld));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic summarize();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [23:0] sat(input longint v);
      if (v > 8388607) return 24'h7fffff;
      if (v < -8388608) return 24'h800000;
      return v[23:0];
   endfunction
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      {rd, addr} <= {1'b1, a};
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("reg", {8'h00, rdata}, {8'h00, e});
   endtask
   // Bounded wait for the output strobe of one path
   task automatic waitv(input logic sel);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while ((sel ? out_vld : dac_vld) !== 1'b1 && k < 4);
      if ((sel ? out_vld : dac_vld) !== 1'b1) begin
         n_fail++;
         summarize();
      end
   endtask
   // Sidetone case: held samples need two cycles to reach the scaled register
   task automatic mix(input logic [15:0] cfg, input logic rm, input logic [23:0] al,
                      input longint il, input longint sl, input longint sr);
      wreg(8'h20, cfg);
      rates_match <= rm;
      far_u.adc(al, -24'sd65536);
      waitv(1'b1);
      repeat (3) @(posedge clk);
      far_u.ifw(il[23:0], 24'sd2000);
      waitv(1'b0);
      chk("stl", dac_l, sat(il + sl));
      chk("str", dac_r, sat(2000 + sr));
   endtask

   initial begin
      {wr, rd, rates_match, addr, wdata} = '0;
      rst = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rreg(8'h18, 16'h0050);
      rreg(8'h20, 16'h0000);
      rreg(8'h26, 16'h0000);
      wreg(8'h18, 16'hffff);
      rreg(8'h18, 16'h1ef0);
      wreg(8'h1a, 16'hffff);
      rreg(8'h1a, 16'h0000);
      wreg(8'h20, 16'hffff);
      rreg(8'h20, 16'h0fff);
      wreg(8'h26, 16'hffff);
      rreg(8'h26, 16'h0003);
      for (int i = 0; i < 16; i++) begin
         wreg(8'h18, {8'h00, i[3:2], 6'h00});
         wreg(8'h26, {14'h0000, i[1:0]});
         far_u.adc(24'h800000, 24'sd12345);
         waitv(1'b1);
         el = sat(i[1] ? 8388608 : -8388608);
         er = sat(i[0] ? -12345 : 12345);
         chk("ifl", out_l, i[3] ? er : el);
         chk("ifr", out_r, i[2] ? er : el);
      end
      // Large left word clips only at the top boost setting
      for (int i = 0; i < 64; i++) begin
         wreg(8'h18, {3'h0, i[5:2], 3'h0, i[1:0], 4'h0});
         far_u.ifw(24'h1f0000, -24'sd291);
         waitv(1'b0);
         el = sat((i[1] ? -291 : 2031616) * (i[5] ? -1 : 1) * (1 << i[3:2]));
         er = sat((i[0] ? -291 : 2031616) * (i[4] ? -1 : 1) * (1 << i[3:2]));
         chk("dacl", dac_l, el);
         chk("dacr", dac_r, er);
      end
      // Full-scale word at the top boost must clamp on both lanes
      wreg(8'h18, 16'h0600);
      far_u.ifw(24'h7fffff, 24'sd5);
      waitv(1'b0);
      chk("satl", dac_l, 24'h7fffff);
      chk("satr", dac_r, 24'h7fffff);
      wreg(8'h18, 16'h0010);
      mix(16'h0ca9, 1'b1, 24'h040000, 1000, -65536, 8 * 16423);
      mix(16'h0006, 1'b1, 24'h040000, 1000, 8 * 519, -2 * 519);
      mix(16'h0ffe, 1'b1, 24'h040000, 1000, 0, -65536);
      mix(16'h0c05, 1'b1, 24'h7fffff, 0, 8388607, 256 * 519 - 1);
      mix(16'hcc09, 1'b0, 24'h040000, 1000, 0, 0);
      summarize();
   end
endmodule // testbench
